/* pkg/rgs_pkg.sv */
package rgs_pkg;

	// frame layout, most significant bit first on the wire
	typedef struct packed {
		logic [3:0] command_field;
		logic [3:0] channel_select_field;
		logic [12:0] unused_bits;
		logic [2:0] setup_bits;
	} rgs_frame_t;

	// setup register fields
	typedef struct packed {
		logic gain_select_bit;
		logic reserved_setup_bit;
		logic reference_disable_bit;
	} rgs_setup_t;

	localparam logic [3:0] RGS_CMD_SETUP = 4'h7;
	localparam logic [6:0] RGS_DEV_ADDR = 7'h0c;
	localparam rgs_setup_t RGS_SETUP_RST = 3'h0;
	localparam logic [3:0] RGS_BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] RGS_LAST_BYTE = 3'h3;
	localparam logic [2:0] RGS_BYTE_SAT = 3'h4;
	localparam int RGS_SYNC_W = 4;

endpackage

/* testbench/rgs_host.sv */
`timescale 1ns/10ps
module rgs_host (
	output logic scl,
	output logic sda_low
);
	localparam int T = 630;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// scl stands high between frames
	task automatic frame(input logic [31:0] w, input int nb);
		sda_low = 1'b1;
		#T scl = 1'b0;
		for (int i = 0; i < nb * 9; i++) begin
			#50 sda_low = (i % 9 < 8) ? !w[31 - (i / 9) * 8 - i % 9] : 1'b0;
			#T scl = 1'b1;
			#T scl = 1'b0;
		end
		#50 sda_low = 1'b1;
		#T scl = 1'b1;
		#T sda_low = 1'b0;
	endtask
endmodule // rgs_host

/* testbench/rgs_setup_checker.sv */
`timescale 1ns/10ps
module rgs_setup_checker
	import rgs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic gain_select_supported,
	input wire logic reference_enable,
	input wire logic gain_two,
	input wire rgs_setup_t setup_reg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_ref; reference_enable == !setup_reg.reference_disable_bit; endproperty
	a_ref: assert property (p_ref) else $error("ref bad");
	property p_gain; $changed(gain_two) |-> gain_two == setup_reg.gain_select_bit; endproperty
	a_gain: assert property (p_gain) else $error("gain bad");
	property p_gsup; $changed(gain_two) |-> gain_select_supported; endproperty
	a_gsup: assert property (p_gsup) else $error("gain moved");
	property p_od; sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("sda driven high");
	property p_apply; $changed(setup_reg) |-> scl && sda_oe; endproperty
	a_apply: assert property (p_apply) else $error("early apply");
	property p_reapply; $changed(reference_enable) |-> scl && sda_oe; endproperty
	a_reapply: assert property (p_reapply) else $error("ref early");
	property p_ackfall; $rose(sda_oe) |-> !scl; endproperty
	a_ackfall: assert property (p_ackfall) else $error("ack edge");
	property p_ackend; sda_oe |-> ##[1:200] !sda_oe; endproperty
	a_ackend: assert property (p_ackend) else $error("ack stuck");
endmodule // rgs_setup_checker
bind rgs_setup_decoder rgs_setup_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl),
	.sda_out(sda_out), .sda_oe(sda_oe), .gain_select_supported(gain_select_supported),
	.reference_enable(reference_enable), .gain_two(gain_two), .setup_reg(setup_reg));

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import rgs_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b0;
	logic gs_sup = 1'b1;
	logic scl, sda_low, sda_oe, sda_out, reference_enable, gain_two;
	rgs_setup_t setup_reg;
	int n_mismatch = 0;
	int checks_done = 0;
	always #5 ref_clk = !ref_clk;
	rgs_host host (.scl(scl), .sda_low(sda_low));
	rgs_setup_decoder uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .scl(scl),
		.sda_in(!(sda_low | sda_oe)), .sda_out(sda_out), .sda_oe(sda_oe),
		.gain_select_supported(gs_sup), .reference_enable(reference_enable),
		.gain_two(gain_two), .setup_reg(setup_reg));
	task chk(input logic [4:0] s, input logic [4:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %h, expected %h", $time, s, e);
		end
	endtask
	// e packs {reference_enable, gain_two, setup_reg}
	task go(input logic [31:0] w, input int nb, input logic [4:0] e);
		host.frame(w, nb);
		repeat (20) @(posedge ref_clk);
		chk({reference_enable, gain_two, setup_reg}, e);
	endtask
	task t_reset;
		chk({reference_enable, gain_two, setup_reg}, 5'h10);
		$display("reset test done");
	endtask
	task t_set;
		go(32'h187ffffd, 4, 5'h0d);
		$display("setup test done");
	endtask
	task t_other;
		go(32'h18f00000, 4, 5'h0d);
		$display("other command test done");
	endtask
	task t_short;
		go(32'h18700000, 3, 5'h0d);
		$display("short frame test done");
	endtask
	task t_nogain;
		@(posedge ref_clk) gs_sup <= 1'b0;
		go(32'h18700000, 4, 5'h18);
		@(posedge ref_clk) gs_sup <= 1'b1;
		go(32'h18700000, 4, 5'h10);
		$display("gain variant test done");
	endtask
	task results;
		$display("checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		ce <= 1'b1;
		repeat (6) @(posedge ref_clk);
		t_reset;
		t_set;
		t_other;
		t_short;
		t_nogain;
		results;
	end
	// five frames take about 235 us
	initial begin
		#600000;
		n_mismatch++;
		results;
	end
endmodule // testbench

/* verilog/rgs_setup_decoder.sv */
`timescale 1ns/10ps
// Summary of operation
// RQ1: reference enabled after power-up, software disables it
// RQ2: lowest setup bit one turns reference off
// RQ3: gain bit selects amplifier gain one or two
// RQ4: variant without gain support ignores gain bit
// RQ5: command code 0111 only does setup
// RQ6: host writes zero to reserved setup bit
// RQ7: channel and don't-care bits are ignored
// RQ8: commands arrive over clock and data wires
// RQ9: only complete 24-bit frames update setup
module rgs_setup_decoder
	import rgs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic gain_select_supported,
	output logic reference_enable,
	output logic gain_two,
	output rgs_setup_t setup_reg
);

	////////////////////////////////////////////////////////////////////////////
	// link domain: bit shifting on the serial clock [RQ8]

	logic link_clr_n;
	logic idle_r;
	logic [3:0] bit_cnt_r;
	logic [2:0] byte_idx_r;
	logic [7:0] shift_r;
	logic addr_ok_r;
	logic [15:0] data_r;
	rgs_frame_t done_frame_r;
	logic done_tgl_r;
	logic want_ack;

	// the serial clock stands still between frames, so framing state is
	// cleared from the reference side while the bus is idle
	assign link_clr_n = rst_n & ~idle_r;

	assign want_ack = (byte_idx_r == 3'h0) ? (shift_r == {RGS_DEV_ADDR, 1'b0})
		: (addr_ok_r && byte_idx_r <= RGS_LAST_BYTE);

	// counts eight data clocks, then the ninth (acknowledge) clock wraps it
	always_ff @(posedge scl or negedge link_clr_n) begin
		if (!link_clr_n) begin
			bit_cnt_r <= 4'h0;
		end else if (bit_cnt_r < RGS_BITS_PER_BYTE) begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end else begin
			bit_cnt_r <= 4'h0;
		end
	end

	// bits enter at the low end, most significant bit first on the wire
	always_ff @(posedge scl or negedge link_clr_n) begin
		if (!link_clr_n) begin
			shift_r <= 8'h00;
		end else if (bit_cnt_r < RGS_BITS_PER_BYTE) begin
			shift_r <= {shift_r[6:0], sda_in};
		end
	end

	// saturates so that extra bytes of a long frame are refused, not wrapped
	always_ff @(posedge scl or negedge link_clr_n) begin
		if (!link_clr_n) begin
			byte_idx_r <= 3'h0;
		end else if (bit_cnt_r == RGS_BITS_PER_BYTE && byte_idx_r != RGS_BYTE_SAT) begin
			byte_idx_r <= byte_idx_r + 3'h1;
		end
	end

	always_ff @(posedge scl or negedge link_clr_n) begin
		if (!link_clr_n) begin
			addr_ok_r <= 1'b0;
		end else if (bit_cnt_r == RGS_BITS_PER_BYTE && byte_idx_r == 3'h0) begin
			addr_ok_r <= (shift_r == {RGS_DEV_ADDR, 1'b0});
		end
	end

	// first two data bytes; the third is taken straight from the shifter
	always_ff @(posedge scl or negedge link_clr_n) begin
		if (!link_clr_n) begin
			data_r <= 16'h0000;
		end else if (bit_cnt_r == RGS_BITS_PER_BYTE && byte_idx_r != 3'h0
			&& byte_idx_r < RGS_LAST_BYTE) begin
			data_r <= {data_r[7:0], shift_r};
		end
	end

	// a frame is handed over only after its third data byte [RQ9]
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			done_frame_r <= '0;
			done_tgl_r <= 1'b0;
		end else if (link_clr_n && bit_cnt_r == RGS_BITS_PER_BYTE && addr_ok_r
			&& byte_idx_r == RGS_LAST_BYTE) begin
			done_frame_r <= {data_r, shift_r};
			done_tgl_r <= ~done_tgl_r;
		end
	end

	// acknowledge is driven from the falling edge so it is stable for the ninth clock
	always_ff @(negedge scl or negedge link_clr_n) begin
		if (!link_clr_n)
			sda_oe <= 1'b0;
		else
			sda_oe <= (bit_cnt_r == RGS_BITS_PER_BYTE) && want_ack;
	end

	// open drain: the pin only ever pulls low, so this level register stays zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else if (ce) begin
			sda_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reference clock domain: start and stop detection

	logic [RGS_SYNC_W-1:0] sync_q;
	logic scl_s, sda_s, tgl_s, gain_sup_s;
	logic sda_d_r, tgl_d_r, start_pend_r;
	logic start_det, stop_det;

	rgs_sync #(.W(RGS_SYNC_W)) u_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.d({scl, sda_in, done_tgl_r, gain_select_supported}),
		.q(sync_q)
	);

	assign {scl_s, sda_s, tgl_s, gain_sup_s} = sync_q;
	assign start_det = scl_s && sda_d_r && !sda_s;
	assign stop_det = scl_s && !sda_d_r && sda_s;

	// idles high like the pulled-up line, so no false start follows reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_d_r <= 1'b1;
		end else if (ce) begin
			sda_d_r <= sda_s;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_d_r <= 1'b0;
		end else if (ce) begin
			tgl_d_r <= tgl_s;
		end
	end

	// a start pulses the clear once so a repeated start restarts framing;
	// the release lands long before the first falling serial clock
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_pend_r <= 1'b0;
		end else if (ce) begin
			start_pend_r <= start_det;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_r <= 1'b1;
		end else if (ce) begin
			if (start_det || stop_det) begin
				idle_r <= 1'b1;
			end else if (start_pend_r) begin
				idle_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// setup register

	logic apply;
	assign apply = (tgl_s != tgl_d_r) && (done_frame_r.command_field == RGS_CMD_SETUP);

	// channel, don't-care and reserved bits are stored but steer nothing [RQ7] [RQ6]
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_reg <= RGS_SETUP_RST;
		end else if (ce && apply) begin // [RQ5]
			setup_reg <= done_frame_r.setup_bits;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reference_enable <= 1'b1; // [RQ1]
		end else if (ce && apply) begin // [RQ5]
			reference_enable <= !done_frame_r.setup_bits[0]; // [RQ2]
		end
	end

	// without gain support the last gain stands, although the bit is still stored
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_two <= 1'b0; // [RQ3]
		end else if (ce && apply && gain_sup_s) begin // [RQ4]
			gain_two <= done_frame_r.setup_bits[2]; // [RQ3]
		end
	end

endmodule // rgs_setup_decoder

/* verilog/rgs_sync.sv */
`timescale 1ns/10ps
module rgs_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // rgs_sync
